/* lsd_pkg.sv */
// package: register map, field layout and types for the segment lcd driver
package lsd_pkg;
  localparam int NUM_PINS = 29;
  localparam int MAX_FP = 28;
  localparam int MAX_BP = 8;
  // register byte offsets (global)
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_SUPPLY = 8'h08;
  localparam logic [7:0] OFS_BLINK = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_BPMAP = 8'h14;
  // per-pin registers, write only
  localparam logic [7:0] OFS_PINEN = 8'h20;
  localparam logic [7:0] OFS_BPSEL = 8'h24;
  localparam logic [7:0] OFS_WFBASE = 8'h40;
  localparam logic [7:0] OFS_WFLAST = 8'hB0;
  localparam logic [7:0] OFS_ALTBASE = 8'hC0;
  localparam logic [7:0] OFS_ALTLAST = 8'hFC;
  // control 0 fields
  localparam int C0_EN = 7;
  localparam int C0_SRC = 6;
  localparam int C0_PRE_LO = 3;
  localparam int C0_DUTY_LO = 0;
  localparam logic [7:0] CTRL0_RST = 8'h03;
  // control 1 fields
  localparam int C1_FIE = 7;
  localparam int C1_WAIDIS = 1;
  localparam int C1_STPDIS = 0;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] SUPPLY_RST = 8'h00;
  // blink fields
  localparam int BL_EN = 7;
  localparam int BL_ALT = 6;
  localparam int BL_RATE_LO = 0;
  localparam logic [7:0] BLINK_RST = 8'h00;
  localparam int ST_FRM = 7;
  localparam logic [23:0] BPMAP_RST = 24'hFAC688;
  localparam int PHASE_BASE = 8;
  localparam int Y_LOOKUP = 2;
  typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP} lsd_pwr_e;
  typedef struct packed {
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] isBp;
    logic [NUM_PINS-1:0] oe;
  } lsd_pins_s;
endpackage

/* lsd_segment_driver.sv */
// segment lcd driver: ahb-lite registers, phase sequencer, pin drive
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
module lsd_segment_driver
  import lsd_pkg::*;
#(
  parameter int BLINK_FRAMES_MIN = 4
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // lcd clock sources, from other clock domain
  input wire logic extRefClk,
  input wire logic altClk,
  // power mode requests
  input wire logic stopMode,
  input wire logic waitMode,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // panel pins and interrupt
  output lsd_pins_s pins,
  output logic frameIrq
);
  // synchronisers for the lcd clock sources
  logic extMeta_ff;
  logic extSync_ff;
  logic extLast_ff;
  logic altMeta_ff;
  logic altSync_ff;
  logic altLast_ff;
  // registers
  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [7:0] supply_ff;
  logic [7:0] blink_ff;
  logic frameFlag_ff;
  logic [23:0] bpMap_ff;
  logic [NUM_PINS-1:0] pinEn_ff;
  logic [NUM_PINS-1:0] bpSel_ff;
  logic [7:0] wf_ff [NUM_PINS];
  logic [7:0] alt_ff [NUM_PINS];
  // bus pipeline
  logic wrPend_ff;
  logic [7:0] addr_ff;
  logic [31:0] rdData_ff;
  logic readyOut_ff;
  logic respErr_ff;
  // sequencer
  logic [15:0] preCnt_ff;
  logic [2:0] phase_ff;
  logic [15:0] blinkCnt_ff;
  logic blinkOn_ff;
  lsd_pins_s pins_ff;
  logic irq_ff;

  // two flops before any edge logic reads the clock pins
  always_ff @(posedge clk)
  begin
    extMeta_ff <= extRefClk;
    extSync_ff <= extMeta_ff;
    extLast_ff <= extSync_ff;
    altMeta_ff <= altClk;
    altSync_ff <= altMeta_ff;
    altLast_ff <= altSync_ff;
  end

  // source select and tick
  wire srcAlt = ctrl0_ff[C0_SRC];
  wire extRise = extSync_ff & ~extLast_ff;
  wire altRise = altSync_ff & ~altLast_ff;
  wire lcdTick = srcAlt ? altRise : extRise;

  // power gating
  wire stopOff = stopMode & ctrl1_ff[C1_STPDIS];
  wire waitOff = waitMode & ctrl1_ff[C1_WAIDIS];
  wire active = ctrl0_ff[C0_EN] & ~stopOff & ~waitOff;

  // frame timing: phase length = 8 * (4 + prescale) * Y lcd ticks
  wire [2:0] duty = ctrl0_ff[C0_DUTY_LO +: 3];
  wire [2:0] pre = ctrl0_ff[C0_PRE_LO +: 3];
  wire [15:0] phaseLen = 16'(PHASE_BASE * (4 + int'(pre)) * Y_LOOKUP);
  wire phaseEnd = active & lcdTick & (preCnt_ff >= phaseLen - 16'h0001);
  wire frameEnd = phaseEnd & (phase_ff == duty);

  // bus decode
  wire accept = hsel & hready & htrans[1];
  wire rdAccept = accept & ~hwrite;
  wire wrAccept = accept & hwrite;
  wire [7:0] wAddr = addr_ff;
  wire inWf = (wAddr >= OFS_WFBASE) && (wAddr <= OFS_WFLAST);
  wire inAlt = (wAddr >= OFS_ALTBASE) && (wAddr <= OFS_ALTLAST);
  wire [4:0] wfIdx = 5'((wAddr - OFS_WFBASE) >> 2);
  wire [4:0] altIdx = 5'((wAddr - OFS_ALTBASE) >> 2);

  function automatic logic [31:0] readMux(
    input logic [7:0] a,
    input logic [7:0] c0,
    input logic [7:0] c1,
    input logic [7:0] su,
    input logic [7:0] bl,
    input logic fl,
    input logic [23:0] bm
  );
    case (a)
      OFS_CTRL0: readMux = {24'h000000, c0};
      OFS_CTRL1: readMux = {24'h000000, c1};
      OFS_SUPPLY: readMux = {24'h000000, su};
      OFS_BLINK: readMux = {24'h000000, bl};
      OFS_STATUS: readMux = {24'h000000, fl, 7'h00};
      OFS_BPMAP: readMux = {8'h00, bm};
      default: readMux = 32'h00000000;
    endcase
  endfunction

  wire [31:0] rdNext = readMux(
    haddr[7:0],
    ctrl0_ff,
    ctrl1_ff,
    supply_ff,
    blink_ff,
    frameFlag_ff,
    bpMap_ff
  );
  wire clrFlag = wrPend_ff & (wAddr == OFS_STATUS) & hwdata[ST_FRM];

  // write strobes for the global and pin registers
  wire wrCtrl0 = wrPend_ff & (wAddr == OFS_CTRL0);
  wire wrCtrl1 = wrPend_ff & (wAddr == OFS_CTRL1);
  wire wrSupply = wrPend_ff & (wAddr == OFS_SUPPLY);
  wire wrBlink = wrPend_ff & (wAddr == OFS_BLINK);
  wire wrBpMap = wrPend_ff & (wAddr == OFS_BPMAP);
  wire wrPinEn = wrPend_ff & (wAddr == OFS_PINEN);
  wire wrBpSel = wrPend_ff & (wAddr == OFS_BPSEL);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPend_ff <= 1'b0;
      addr_ff <= 8'h00;
      rdData_ff <= 32'h00000000;
    end
    else
    begin
      wrPend_ff <= wrAccept;
      if (accept)
        addr_ff <= haddr[7:0];
      rdData_ff <= rdAccept ? rdNext : 32'h00000000;
    end
  end

  // bus handshake outputs: no wait states, always okay
  always_ff @(posedge clk)
  begin
    readyOut_ff <= 1'b1;
    respErr_ff <= 1'b0;
  end

  // global registers, pin enables and backplane selects
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl0_ff <= CTRL0_RST;
      ctrl1_ff <= CTRL1_RST;
      supply_ff <= SUPPLY_RST;
      blink_ff <= BLINK_RST;
      bpMap_ff <= BPMAP_RST;
      pinEn_ff <= '0;
      bpSel_ff <= '0;
    end
    else
    begin
      if (wrCtrl0)
        ctrl0_ff <= hwdata[7:0];
      if (wrCtrl1)
        ctrl1_ff <= hwdata[7:0];
      if (wrSupply)
        supply_ff <= hwdata[7:0];
      if (wrBlink)
        blink_ff <= hwdata[7:0];
      if (wrBpMap)
        bpMap_ff <= hwdata[23:0];
      if (wrPinEn)
        pinEn_ff <= hwdata[NUM_PINS-1:0];
      if (wrBpSel)
        bpSel_ff <= hwdata[NUM_PINS-1:0];
    end
  end

  // frame flag: set wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
      frameFlag_ff <= 1'b0;
    else if (frameEnd)
      frameFlag_ff <= 1'b1;
    else if (clrFlag)
      frameFlag_ff <= 1'b0;
  end

  // waveform storage, one byte per pin, bit n = phase n
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_wf
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          wf_ff[gi] <= 8'h00;
          alt_ff[gi] <= 8'h00;
        end
        else
        begin
          if (wrPend_ff & inWf & (wfIdx == 5'(gi)))
            wf_ff[gi] <= hwdata[7:0];
          if (wrPend_ff & inAlt & (altIdx == 5'(gi)))
            alt_ff[gi] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  // phase sequencer
  always_ff @(posedge clk)
  begin
    if (rst | ~active)
    begin
      preCnt_ff <= 16'h0000;
      phase_ff <= 3'h0;
    end
    else if (lcdTick)
    begin
      preCnt_ff <= phaseEnd ? 16'h0000 : preCnt_ff + 16'h0001;
      if (phaseEnd)
        phase_ff <= (phase_ff == duty) ? 3'h0 : phase_ff + 3'h1;
    end
  end

  // blink timer counts frames, runs in any mode while active
  wire [2:0] blinkRate = blink_ff[BL_RATE_LO +: 3];
  wire [15:0] blinkLen = 16'(BLINK_FRAMES_MIN) << blinkRate;
  wire blinkWrap = (blinkCnt_ff >= blinkLen - 16'h0001);
  always_ff @(posedge clk)
  begin
    if (rst | ~active | ~blink_ff[BL_EN])
    begin
      blinkCnt_ff <= 16'h0000;
      blinkOn_ff <= 1'b0;
    end
    else if (frameEnd)
    begin
      if (blinkWrap)
      begin
        blinkCnt_ff <= 16'h0000;
        blinkOn_ff <= ~blinkOn_ff;
      end
      else
        blinkCnt_ff <= blinkCnt_ff + 16'h0001;
    end
  end

  wire altOk = (duty <= 3'h3);
  wire useAlt = blinkOn_ff & blink_ff[BL_ALT] & altOk;
  wire blank = blinkOn_ff & ~useAlt;

  // pin drive
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      wire [2:0] bpPhase = bpMap_ff[3*(gi%MAX_BP) +: 3];
      wire [7:0] segs = useAlt ? alt_ff[gi] : wf_ff[gi];
      wire fpLvl = ~blank & segs[phase_ff];
      wire bpLvl = (bpPhase == phase_ff);
      // next pin drive values
      wire oeNext = active & pinEn_ff[gi];
      wire lvlNext = active & (bpSel_ff[gi] ? bpLvl : fpLvl);
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          pins_ff.oe[gi] <= 1'b0;
          pins_ff.level[gi] <= 1'b0;
          pins_ff.isBp[gi] <= 1'b0;
        end
        else
        begin
          pins_ff.oe[gi] <= oeNext;
          pins_ff.isBp[gi] <= bpSel_ff[gi];
          pins_ff.level[gi] <= lvlNext;
        end
      end
    end
  endgenerate

  // interrupt request, usable as wake from stop or wait
  wire irqNext = (frameFlag_ff | frameEnd) & ctrl1_ff[C1_FIE];
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= irqNext;
  end

  assign hrdata = rdData_ff;
  assign hreadyout = readyOut_ff;
  assign hresp = respErr_ff;
  assign pins = pins_ff;
  assign frameIrq = irq_ff;
endmodule

/* lsd_segment_driver_properties.sv */
// checker: bus and pin properties of the segment lcd driver
module lsd_segment_driver_properties
  import lsd_pkg::*;
#(
  parameter int BLINK_FRAMES_MIN = 4
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // panel
  input wire lsd_pins_s pins,
  input wire logic frameIrq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rdReq;
  assign rdReq = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_high: assert property (hreadyout) else $error("bus stalled");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_rdata_idle: assert property (!rdReq |=> hrdata == 32'h0)
    else $error("stray read data");
  a_pin_read: assert property (rdReq && haddr[7:0] >= OFS_PINEN |=> hrdata == 32'h0)
    else $error("pin register readable");
  a_reset_pins: assert property (disable iff (1'h0) rst |=> pins.oe == '0)
    else $error("pins driven after reset");
  a_reset_irq: assert property (disable iff (1'h0) rst |=> !frameIrq)
    else $error("irq in reset");
  a_bp_limit: assert property ($countones(pins.oe & pins.isBp) <= MAX_BP)
    else $error("too many backplanes");
  a_one_phase: assert property ($onehot0(pins.oe & pins.isBp & pins.level))
    else $error("two backplanes active");
  c_read: cover property (rdReq);
  c_irq: cover property ($rose(frameIrq));
  c_bp_on: cover property (|(pins.oe & pins.isBp & pins.level));
endmodule
bind lsd_segment_driver lsd_segment_driver_properties #(.BLINK_FRAMES_MIN(BLINK_FRAMES_MIN))
  chk (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
  .frameIrq(frameIrq));

/* lsd_glass_model.sv */
// glass model: records segments lit or dark under each backplane
module lsd_glass_model
  import lsd_pkg::*;
(
  // clock and clear
  input wire logic clk,
  input wire logic clr,
  // panel pins
  input wire lsd_pins_s pins,
  // seen maps per frontplane, one bit per backplane
  output logic [NUM_PINS-1:0][7:0] litMap,
  output logic [NUM_PINS-1:0][7:0] darkMap
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [NUM_PINS-1:0] fpOn, fpOff;
  logic [7:0] bpOn;
  assign fpOn = pins.oe & ~pins.isBp & pins.level;
  assign fpOff = pins.oe & ~pins.isBp & ~pins.level;
  assign bpOn = pins.oe[7:0] & pins.isBp[7:0] & pins.level[7:0];
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      litMap[i] <= clr ? 8'h00 : litMap[i] | (fpOn[i] ? bpOn : 8'h00);
      darkMap[i] <= clr ? 8'h00 : darkMap[i] | (fpOff[i] ? bpOn : 8'h00);
    end
  end
endmodule

/* lsd_segment_driver_bench.sv */
// bench: register, panel and power-mode tests of the segment lcd driver
module lsd_segment_driver_bench
  import lsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FRAME = 1600;
  logic clk = 1'h0, rst = 1'h1, extRefClk = 1'h0, altClk = 1'h0, refOn = 1'h1, clr = 1'h0;
  logic stopMode = 1'h0, waitMode = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0, div = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic hreadyout, hresp, frameIrq;
  lsd_pins_s pins;
  logic [NUM_PINS-1:0][7:0] litMap, darkMap;
  logic [7:0] wfShadow [2];
  logic [7:0] ga [4] = '{OFS_CTRL1, OFS_SUPPLY, OFS_BLINK, OFS_CTRL0};
  logic [31:0] gv [4] = '{32'h83, 32'h5A, 32'h45, 32'h3B};
  logic [7:0] pa [4] = '{OFS_PINEN, OFS_BPSEL, OFS_WFBASE, 8'h30};
  logic [7:0] c1 [4] = '{8'h80, 8'h81, 8'h80, 8'h82};
  logic [1:0] md [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
  logic on [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  int failures = 0, compares = 0;
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    if (div == 2'h0)
      extRefClk <= refOn & ~extRefClk;
    altClk <= ~altClk;
  end
  lsd_segment_driver #(.BLINK_FRAMES_MIN(1)) uut (.clk(clk), .rst(rst), .extRefClk(extRefClk),
    .altClk(altClk), .stopMode(stopMode), .waitMode(waitMode), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .frameIrq(frameIrq));
  lsd_glass_model glass (.clk(clk), .clr(clr), .pins(pins), .litMap(litMap), .darkMap(darkMap));
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rdv = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), rdv, exp);
  endtask
  task waitOe(input logic [28:0] exp);
    for (int n = 0; n < 40 && pins.oe !== exp; n++)
      @(posedge clk);
    chk("pin enables", {3'h0, pins.oe}, {3'h0, exp});
  endtask
  task run(input int n);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    repeat (n * FRAME) @(posedge clk);
  endtask
  task end_sim();
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #600000;
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    waitOe(29'h0);
    rd(OFS_CTRL0, 32'h03);
    rd(OFS_BPMAP, 32'h00FAC688);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'h1, ga[k], gv[k]);
      rd(ga[k], gv[k]);
      xfer(1'h1, pa[k], 32'hFF);
      rd(pa[k], 32'h0);
    end
    wfShadow[0] = 8'h05;
    wfShadow[1] = 8'h0A;
    xfer(1'h1, OFS_WFBASE + 8'h10, {24'h0, wfShadow[0]});
    xfer(1'h1, OFS_WFBASE + 8'h14, {24'h0, wfShadow[1]});
    xfer(1'h1, OFS_ALTBASE + 8'h10, 32'h02);
    xfer(1'h1, OFS_PINEN, 32'h3F);
    xfer(1'h1, OFS_BPSEL, 32'h0F);
    xfer(1'h1, OFS_CTRL1, 32'h80);
    waitOe(29'h0);
    xfer(1'h1, OFS_CTRL0, 32'h83);
    waitOe(29'h3F);
    chk("backplanes", {3'h0, pins.oe & pins.isBp}, 32'h0F);
    run(2);
    chk("segments", {16'h0, litMap[5], litMap[4]}, 32'h0A05);
    chk("irq", {31'h0, frameIrq}, 32'h1);
    rd(OFS_STATUS, 32'h80);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'h1, OFS_CTRL1, {24'h0, c1[k]});
      xfer(1'h1, OFS_STATUS, 32'h80);
      {waitMode, stopMode} <= md[k];
      waitOe(on[k] ? 29'h3F : 29'h0);
      run(1);
      chk("wake", {31'h0, frameIrq}, {31'h0, on[k]});
      {waitMode, stopMode} <= 2'h0;
    end
    xfer(1'h1, OFS_BLINK, 32'h80);
    stopMode <= 1'h1;
    run(4);
    chk("blank", {30'h0, darkMap[4][0], litMap[4][0]}, 32'h3);
    xfer(1'h1, OFS_BLINK, 32'hC0);
    run(4);
    chk("alternate", {24'h0, litMap[4]}, 32'h07);
    xfer(1'h1, OFS_CTRL0, 32'h03);
    xfer(1'h1, OFS_CTRL0, 32'h84);
    run(4);
    chk("no alternate", {24'h0, litMap[4]}, 32'h05);
    xfer(1'h1, OFS_BLINK, 32'h0);
    stopMode <= 1'h0;
    xfer(1'h1, OFS_BPMAP, 32'h00FAC681);
    run(2);
    chk("reassigned", {16'h0, litMap[5], litMap[4]}, 32'h0906);
    xfer(1'h1, OFS_CTRL0, 32'h03);
    xfer(1'h1, OFS_CTRL0, 32'hC3);
    refOn <= 1'h0;
    xfer(1'h1, OFS_STATUS, 32'h80);
    run(1);
    rd(OFS_STATUS, 32'h80);
    end_sim();
  end
endmodule
